/* File: hdl/cltb_alu.sv */
// subtractor with condition flags for compare and decrement
`timescale 1ns/1ps
module cltb_alu (
	input  wire logic [15:0] a_i,
	input  wire logic [15:0] b_i,
	input  wire logic        word_i,
	output logic      [15:0] diff_o,
	output logic             n_o,
	output logic             z_o,
	output logic             v_o,
	output logic             c_o
);
	logic [16:0] full;
	logic        sa;
	logic        sb;
	logic        sd;

	always_comb begin
		full = {1'b0, a_i} - {1'b0, b_i};
		if (word_i) begin
			diff_o = full[15:0];
			c_o    = full[16];
			z_o    = (full[15:0] == 16'h0000);
			sa     = a_i[15];
			sb     = b_i[15];
			sd     = full[15];
		end else begin
			// byte: upper lane forced to zero, borrow from unsigned compare of the low bytes
			diff_o = {8'h00, a_i[7:0] - b_i[7:0]};
			c_o    = (a_i[7:0] < b_i[7:0]);
			z_o    = (diff_o[7:0] == 8'h00);
			sa     = a_i[7];
			sb     = b_i[7];
			sd     = diff_o[7];
		end
		n_o = sd;
		v_o = (sa ^ sb) & (sa ^ sd);
	end
endmodule : cltb_alu

/* File: hdl/cltb_map.svh */
// offsets, field positions, reset values and cycle counts of the branch sequencer
//
// Overview of operation
// - byte accumulator compare with imm8, branch if unequal, set N Z V C.
// - word accumulator compare with imm16, branch if unequal, four-byte encoding, N Z V C.
// - register or memory operand compared with same-width immediate; register form one bank access.
// - byte loop decrements, writes back, branches if nonzero, sets N Z V, keeps C.
// - word loop same on 16 bits; memory operand uses read-modify-write, two transfers.
// - traps clear interrupt enable, set stack select; vector form 20 cycles, eight transfers.
// - trap return restores whole status word from stack, 15 cycles, six transfers.
// - frame setup pushes frame pointer, loads new one, reserves imm8 bytes, 6 cycles.
// - frame teardown restores frame pointer in 5 cycles, single byte, flags unchanged.
// - near exit 4 cycles, far exit 6 cycles, single byte, flags unchanged.
// - accumulator compare forms take 5 cycles when taken, 4 when not.
// - near exit pops 16-bit program counter; far exit pops counter and bank.
`ifndef CLTB_MAP_SVH
`define CLTB_MAP_SVH

// ----------------------------------------------------------------------------
// status word bit positions
// ----------------------------------------------------------------------------
`define CLTB_FLAG_C        0
`define CLTB_FLAG_V        1
`define CLTB_FLAG_Z        2
`define CLTB_FLAG_N        3
`define CLTB_FLAG_T        4
`define CLTB_FLAG_S        5
`define CLTB_FLAG_I        6

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CLTB_RST_WORD      16'h0000
`define CLTB_RST_BYTE      8'h00
`define CLTB_RST_LONG      32'h0000_0000
`define CLTB_RST_ADDR      24'h00_0000

// ----------------------------------------------------------------------------
// trap vector table
// ----------------------------------------------------------------------------
`define CLTB_VECT_TOP      24'hff_fffc
`define CLTB_SINGLE_VECT   8'h09

// ----------------------------------------------------------------------------
// cycle counts (not-taken figure; a taken branch adds one)
// ----------------------------------------------------------------------------
`define CLTB_CYC_CMP_ACC   5'h04
`define CLTB_CYC_CMPB_REG  5'h0c
`define CLTB_CYC_CMPW_REG  5'h07
`define CLTB_CYC_CMP_MEM   5'h06
`define CLTB_CYC_DEC_REG   5'h06
`define CLTB_CYC_DEC_MEM   5'h07
`define CLTB_CYC_TRAP_VEC  5'h14
`define CLTB_CYC_TRAP_NEAR 5'h10
`define CLTB_CYC_TRAP_FAR  5'h11
`define CLTB_CYC_RESUME    5'h0f
`define CLTB_CYC_SETUP     5'h06
`define CLTB_CYC_TEARDOWN  5'h05
`define CLTB_CYC_EXIT      5'h04
`define CLTB_CYC_FAR_EXIT  5'h06

// ----------------------------------------------------------------------------
// data transfer counts
// ----------------------------------------------------------------------------
`define CLTB_XF_PUSHES     4'h6
`define CLTB_XF_VEC_TRAP   4'h8

`endif

/* File: hdl/cltb_pkg.sv */
// types shared by the branch sequencer
package cltb_pkg;

	typedef enum logic [4:0] {
		cmp_byte_acc,
		cmp_word_acc,
		cmp_byte_reg,
		cmp_byte_mem,
		cmp_word_reg,
		cmp_word_mem,
		dec_byte_reg,
		dec_byte_mem,
		dec_word_reg,
		dec_word_mem,
		trap_vector,
		trap_near,
		far_software_trap,
		single_byte_software_trap,
		resume_after_trap,
		frame_setup,
		frame_teardown,
		subroutine_exit,
		far_subroutine_exit
	} cltb_op_t;

	typedef enum logic {
		st_idle,
		st_run
	} cltb_st_t;

	typedef struct packed {
		cltb_st_t    st;
		cltb_op_t    op;
		logic        busy;
		logic        done;
		logic        taken;
		logic        word;
		logic        rd_pend;
		logic        xreq;
		logic        xwe;
		logic        xbyte;
		logic        xrmw;
		logic        wbwe;
		logic        rbrd;
		logic [4:0]  cnt;
		logic [4:0]  tgt;
		logic [3:0]  xi;
		logic [3:0]  nxf;
		logic [15:0] pc;
		logic [15:0] ps;
		logic [15:0] sp;
		logic [15:0] fp;
		logic [15:0] bank;
		logic [15:0] a;
		logic [15:0] imm;
		logic [15:0] sv_pc;
		logic [15:0] sv_ps;
		logic [15:0] wbdata;
		logic [15:0] xwdata;
		logic [7:0]  pcb;
		logic [7:0]  sv_pcb;
		logic [7:0]  sbk;
		logic [7:0]  lcl;
		logic [7:0]  disp;
		logic [31:0] acc;
		logic [23:0] xaddr;
		logic [23:0] oaddr;
		logic [23:0] far;
	} cltb_state_t;

endpackage : cltb_pkg

/* File: hdl/cltb_unit.sv */
// sequencer for compare-branch, loop, trap, frame and return instructions
`timescale 1ns/1ps
`include "cltb_map.svh"
module cltb_unit (
	input  wire logic             clock_i,
	input  wire logic             reset_n_i,
	input  wire logic             start_i,
	input  wire cltb_pkg::cltb_op_t op_i,
	input  wire logic [31:0]      acc_i,
	input  wire logic [15:0]      operand_i,
	input  wire logic [15:0]      imm_i,
	input  wire logic [7:0]       disp_i,
	input  wire logic [7:0]       local_i,
	input  wire logic [7:0]       vector_i,
	input  wire logic [23:0]      far_addr_i,
	input  wire logic [23:0]      opnd_addr_i,
	input  wire logic [3:0]       addr_cycles_i,
	input  wire logic [15:0]      next_pc_i,
	input  wire logic [7:0]       pcb_i,
	input  wire logic [15:0]      ps_i,
	input  wire logic [15:0]      sp_i,
	input  wire logic [15:0]      fp_i,
	input  wire logic [15:0]      bank_i,
	input  wire logic [7:0]       stack_bank_i,
	input  wire logic [15:0]      xfer_rdata_i,
	output logic                  busy_o,
	output logic                  done_o,
	output logic                  branch_o,
	output logic [15:0]           pc_o,
	output logic [7:0]            pcb_o,
	output logic [15:0]           ps_o,
	output logic [15:0]           sp_o,
	output logic [15:0]           fp_o,
	output logic [31:0]           acc_o,
	output logic [15:0]           bank_o,
	output logic                  wb_we_o,
	output logic [15:0]           wb_data_o,
	output logic                  regbank_rd_o,
	output logic                  xfer_req_o,
	output logic                  xfer_we_o,
	output logic                  xfer_byte_o,
	output logic                  xfer_rmw_o,
	output logic [23:0]           xfer_addr_o,
	output logic [15:0]           xfer_wdata_o
);
	// ------------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------------
	function automatic logic is_word(input cltb_pkg::cltb_op_t o);
		is_word = (o == cltb_pkg::cmp_word_acc) || (o == cltb_pkg::cmp_word_reg) ||
			(o == cltb_pkg::cmp_word_mem) || (o == cltb_pkg::dec_word_reg) ||
			(o == cltb_pkg::dec_word_mem);
	endfunction : is_word

	function automatic logic [4:0] cycles(input cltb_pkg::cltb_op_t o, input logic [3:0] ac);
		case (o)
			cltb_pkg::cmp_byte_acc, cltb_pkg::cmp_word_acc: cycles = `CLTB_CYC_CMP_ACC;
			cltb_pkg::cmp_byte_reg: cycles = `CLTB_CYC_CMPB_REG;
			cltb_pkg::cmp_word_reg: cycles = `CLTB_CYC_CMPW_REG;
			cltb_pkg::cmp_byte_mem, cltb_pkg::cmp_word_mem: cycles = `CLTB_CYC_CMP_MEM + {1'b0, ac};
			cltb_pkg::dec_byte_reg, cltb_pkg::dec_word_reg: cycles = `CLTB_CYC_DEC_REG;
			cltb_pkg::dec_byte_mem, cltb_pkg::dec_word_mem: cycles = `CLTB_CYC_DEC_MEM + {1'b0, ac};
			cltb_pkg::trap_vector, cltb_pkg::single_byte_software_trap: cycles = `CLTB_CYC_TRAP_VEC;
			cltb_pkg::trap_near: cycles = `CLTB_CYC_TRAP_NEAR;
			cltb_pkg::far_software_trap: cycles = `CLTB_CYC_TRAP_FAR;
			cltb_pkg::resume_after_trap: cycles = `CLTB_CYC_RESUME;
			cltb_pkg::frame_setup: cycles = `CLTB_CYC_SETUP;
			cltb_pkg::frame_teardown: cycles = `CLTB_CYC_TEARDOWN;
			cltb_pkg::subroutine_exit: cycles = `CLTB_CYC_EXIT;
			default: cycles = `CLTB_CYC_FAR_EXIT;
		endcase
	endfunction : cycles

	function automatic logic [3:0] xfers(input cltb_pkg::cltb_op_t o);
		case (o)
			cltb_pkg::cmp_byte_mem, cltb_pkg::cmp_word_mem: xfers = 4'h1;
			cltb_pkg::dec_byte_mem, cltb_pkg::dec_word_mem: xfers = 4'h2;
			cltb_pkg::trap_vector, cltb_pkg::single_byte_software_trap: xfers = `CLTB_XF_VEC_TRAP;
			cltb_pkg::trap_near, cltb_pkg::far_software_trap: xfers = `CLTB_XF_PUSHES;
			cltb_pkg::resume_after_trap: xfers = `CLTB_XF_PUSHES;
			cltb_pkg::frame_setup, cltb_pkg::frame_teardown: xfers = 4'h1;
			cltb_pkg::subroutine_exit: xfers = 4'h1;
			cltb_pkg::far_subroutine_exit: xfers = 4'h2;
			default: xfers = 4'h0;
		endcase
	endfunction : xfers

	// ------------------------------------------------------------------------
	// state and arithmetic
	// ------------------------------------------------------------------------
	cltb_pkg::cltb_state_t q;
	cltb_pkg::cltb_state_t d;
	logic [15:0]           alu_a;
	logic [15:0]           alu_b;
	logic                  alu_w;
	logic [15:0]           diff;
	logic                  fn;
	logic                  fz;
	logic                  fv;
	logic                  fc;
	logic                  is_dec;
	logic [15:0]           br_pc;
	logic [15:0]           push_w;
	logic [23:0]           vect_a;

	cltb_alu u_alu (
		.a_i    (alu_a),
		.b_i    (alu_b),
		.word_i (alu_w),
		.diff_o (diff),
		.n_o    (fn),
		.z_o    (fz),
		.v_o    (fv),
		.c_o    (fc)
	);

	always_comb begin
		if (q.st == cltb_pkg::st_idle) begin
			is_dec = (op_i >= cltb_pkg::dec_byte_reg) && (op_i <= cltb_pkg::dec_word_mem);
			alu_w  = is_word(op_i);
			alu_a  = ((op_i == cltb_pkg::cmp_byte_acc) || (op_i == cltb_pkg::cmp_word_acc)) ?
				acc_i[15:0] : operand_i;
			alu_b  = is_dec ? 16'h0001 : imm_i;
			br_pc  = next_pc_i + {{8{disp_i[7]}}, disp_i};
		end else begin
			is_dec = (q.op == cltb_pkg::dec_byte_mem) || (q.op == cltb_pkg::dec_word_mem);
			alu_w  = q.word;
			alu_a  = xfer_rdata_i;
			alu_b  = is_dec ? 16'h0001 : q.imm;
			br_pc  = q.sv_pc + {{8{q.disp[7]}}, q.disp};
		end
	end

	always_comb begin
		case (q.xi)
			4'h0: push_w = q.acc[31:16];
			4'h1: push_w = q.acc[15:0];
			4'h2: push_w = q.bank;
			4'h3: push_w = {8'h00, q.sv_pcb};
			4'h4: push_w = q.sv_pc;
			default: push_w = q.sv_ps;
		endcase
		vect_a = `CLTB_VECT_TOP - {14'h0000, q.imm[7:0], 2'b00};
	end

	// ------------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------------
	always_comb begin
		d      = q;
		d.done = 1'b0;
		d.xreq = 1'b0;
		d.xwe  = 1'b0;
		d.xrmw = 1'b0;
		d.wbwe = 1'b0;
		d.rbrd = 1'b0;
		case (q.st)
			cltb_pkg::st_idle: begin
				if (start_i) begin
					d.st      = cltb_pkg::st_run;
					d.busy    = 1'b1;
					d.op      = op_i;
					d.cnt     = 5'h01;
					d.xi      = 4'h0;
					d.rd_pend = 1'b0;
					d.taken   = 1'b0;
					d.word    = is_word(op_i);
					d.xbyte   = ~is_word(op_i);
					d.tgt     = cycles(op_i, addr_cycles_i);
					d.nxf     = xfers(op_i);
					d.imm     = imm_i;
					d.disp    = disp_i;
					d.lcl     = local_i;
					d.far     = far_addr_i;
					d.oaddr   = opnd_addr_i;
					d.sbk     = stack_bank_i;
					d.pc      = next_pc_i;
					d.pcb     = pcb_i;
					d.ps      = ps_i;
					d.sp      = sp_i;
					d.fp      = fp_i;
					d.acc     = acc_i;
					d.bank    = bank_i;
					d.sv_pc   = next_pc_i;
					d.sv_pcb  = pcb_i;
					d.sv_ps   = ps_i;
					case (op_i)
						cltb_pkg::cmp_byte_acc, cltb_pkg::cmp_word_acc,
						cltb_pkg::cmp_byte_reg, cltb_pkg::cmp_word_reg: begin
							d.rbrd = (op_i == cltb_pkg::cmp_byte_reg) ||
								(op_i == cltb_pkg::cmp_word_reg);
							d.ps[`CLTB_FLAG_N] = fn;
							d.ps[`CLTB_FLAG_Z] = fz;
							d.ps[`CLTB_FLAG_V] = fv;
							d.ps[`CLTB_FLAG_C] = fc;
							d.taken = ~fz;
							if (!fz) begin
								d.tgt = cycles(op_i, addr_cycles_i) + 5'h01;
								d.pc  = br_pc;
							end
						end
						cltb_pkg::dec_byte_reg, cltb_pkg::dec_word_reg: begin
							d.rbrd   = 1'b1;
							d.wbwe   = 1'b1;
							d.wbdata = diff;
							d.ps[`CLTB_FLAG_N] = fn;
							d.ps[`CLTB_FLAG_Z] = fz;
							d.ps[`CLTB_FLAG_V] = fv;
							d.taken = ~fz;
							if (!fz) begin
								d.tgt = cycles(op_i, addr_cycles_i) + 5'h01;
								d.pc  = br_pc;
							end
						end
						cltb_pkg::trap_vector, cltb_pkg::single_byte_software_trap,
						cltb_pkg::trap_near, cltb_pkg::far_software_trap: begin
							d.ps[`CLTB_FLAG_I] = 1'b0;
							d.ps[`CLTB_FLAG_S] = 1'b1;
							if (op_i == cltb_pkg::single_byte_software_trap)
								d.imm = {8'h00, `CLTB_SINGLE_VECT};
							else if (op_i == cltb_pkg::trap_vector)
								d.imm = {8'h00, vector_i};
							else if (op_i == cltb_pkg::trap_near)
								d.pc = far_addr_i[15:0];
							else begin
								d.pc  = far_addr_i[15:0];
								d.pcb = far_addr_i[23:16];
							end
						end
						default: begin
						end
					endcase
				end
			end
			cltb_pkg::st_run: begin
				d.cnt = q.cnt + 5'h01;
				if (q.rd_pend) begin
					d.rd_pend = 1'b0;
					case (q.op)
						cltb_pkg::cmp_byte_mem, cltb_pkg::cmp_word_mem: begin
							d.ps[`CLTB_FLAG_N] = fn;
							d.ps[`CLTB_FLAG_Z] = fz;
							d.ps[`CLTB_FLAG_V] = fv;
							d.ps[`CLTB_FLAG_C] = fc;
							d.taken = ~fz;
							if (!fz) begin
								d.tgt = q.tgt + 5'h01;
								d.pc  = br_pc;
							end
						end
						cltb_pkg::dec_byte_mem, cltb_pkg::dec_word_mem: begin
							d.a = diff;
							d.ps[`CLTB_FLAG_N] = fn;
							d.ps[`CLTB_FLAG_Z] = fz;
							d.ps[`CLTB_FLAG_V] = fv;
							d.taken = ~fz;
							if (!fz) begin
								d.tgt = q.tgt + 5'h01;
								d.pc  = br_pc;
							end
						end
						cltb_pkg::resume_after_trap: begin
							case (q.xi)
								4'h1: d.ps = xfer_rdata_i;
								4'h2: d.pc = xfer_rdata_i;
								4'h3: d.pcb = xfer_rdata_i[7:0];
								4'h4: d.bank = xfer_rdata_i;
								4'h5: d.acc[15:0] = xfer_rdata_i;
								default: d.acc[31:16] = xfer_rdata_i;
							endcase
						end
						cltb_pkg::frame_teardown: d.fp = xfer_rdata_i;
						default: begin
							// vector fetch or return pops: word then bank
							if ((q.op == cltb_pkg::far_subroutine_exit) && (q.xi == q.nxf))
								d.pcb = xfer_rdata_i[7:0];
							else
								d.pc = xfer_rdata_i;
							if ((q.op == cltb_pkg::trap_vector) ||
								(q.op == cltb_pkg::single_byte_software_trap)) begin
								if (q.xi == 4'h7)
									d.pc = xfer_rdata_i;
								else
									d.pcb = xfer_rdata_i[7:0];
							end
						end
					endcase
				end else if (q.xi < q.nxf) begin
					d.xreq = 1'b1;
					d.xi   = q.xi + 4'h1;
					d.xwe  = 1'b0;
					d.rd_pend = 1'b1;
					d.xbyte = 1'b0;
					d.xaddr = {q.sbk, q.sp};
					case (q.op)
						cltb_pkg::cmp_byte_mem, cltb_pkg::cmp_word_mem: begin
							// address comes from the operand unit as is, post-increment never arrives
							d.xaddr = q.oaddr;
							d.xbyte = ~q.word;
						end
						cltb_pkg::dec_byte_mem, cltb_pkg::dec_word_mem: begin
							d.xaddr = q.oaddr;
							d.xbyte = ~q.word;
							d.xrmw  = 1'b1;
							if (q.xi == 4'h1) begin
								d.xwe     = 1'b1;
								d.rd_pend = 1'b0;
								d.xwdata  = q.a;
							end
						end
						cltb_pkg::trap_vector, cltb_pkg::single_byte_software_trap,
						cltb_pkg::trap_near, cltb_pkg::far_software_trap: begin
							if (q.xi < `CLTB_XF_PUSHES) begin
								d.sp      = q.sp - 16'h0002;
								d.xaddr   = {q.sbk, q.sp - 16'h0002};
								d.xwe     = 1'b1;
								d.rd_pend = 1'b0;
								d.xwdata  = push_w;
							end else if (q.xi == `CLTB_XF_PUSHES)
								d.xaddr = vect_a;
							else
								d.xaddr = vect_a + 24'h00_0002;
						end
						cltb_pkg::frame_setup: begin
							d.xaddr   = {q.sbk, q.sp - 16'h0002};
							d.xwe     = 1'b1;
							d.rd_pend = 1'b0;
							d.xwdata  = q.fp;
							d.fp      = q.sp - 16'h0002;
							d.sp      = q.sp - 16'h0002 - {8'h00, q.lcl};
						end
						cltb_pkg::frame_teardown: begin
							d.xaddr = {q.sbk, q.fp};
							d.sp    = q.fp + 16'h0002;
						end
						default: d.sp = q.sp + 16'h0002;
					endcase
				end
				if (q.cnt == q.tgt - 5'h01) begin
					d.st   = cltb_pkg::st_idle;
					d.busy = 1'b0;
					d.done = 1'b1;
				end
			end
			default: d.st = cltb_pkg::st_idle;
		endcase
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i)
			q <= '0;
		else
			q <= d;
	end

	// ------------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------------
	assign busy_o       = q.busy;
	assign done_o       = q.done;
	assign branch_o     = q.taken;
	assign pc_o         = q.pc;
	assign pcb_o        = q.pcb;
	assign ps_o         = q.ps;
	assign sp_o         = q.sp;
	assign fp_o         = q.fp;
	assign acc_o        = q.acc;
	assign bank_o       = q.bank;
	assign wb_we_o      = q.wbwe;
	assign wb_data_o    = q.wbdata;
	assign regbank_rd_o = q.rbrd;
	assign xfer_req_o   = q.xreq;
	assign xfer_we_o    = q.xwe;
	assign xfer_byte_o  = q.xbyte;
	assign xfer_rmw_o   = q.xrmw;
	assign xfer_addr_o  = q.xaddr;
	assign xfer_wdata_o = q.xwdata;

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_go(cltb_pkg::cltb_op_t o);
		!busy_o && start_i && (op_i == o);
	endsequence

	a_cmp_taken_time: assert property (s_go(cltb_pkg::cmp_byte_acc) ##0 (acc_i[7:0] != imm_i[7:0])
		|-> ##5 (done_o && branch_o)) else $error("byte compare taken timing");
	a_cmp_fall_time: assert property (s_go(cltb_pkg::cmp_word_acc) ##0 (acc_i[15:0] == imm_i)
		|-> (!done_o) [*4] ##1 (done_o && !branch_o && ps_o[`CLTB_FLAG_Z]))
		else $error("word compare fall-through");
	a_trap_vec_time: assert property (s_go(cltb_pkg::trap_vector) |-> ##20 done_o)
		else $error("vector trap length");
	a_trap_flags: assert property (s_go(cltb_pkg::far_software_trap)
		|=> !ps_o[`CLTB_FLAG_I] && ps_o[`CLTB_FLAG_S]) else $error("trap flags");
	a_resume_time: assert property (s_go(cltb_pkg::resume_after_trap) |-> ##15 done_o)
		else $error("trap return length");
	a_setup_time: assert property (s_go(cltb_pkg::frame_setup) |-> ##6 done_o)
		else $error("frame setup length");
	a_teardown_flags: assert property (s_go(cltb_pkg::frame_teardown)
		|=> (ps_o == $past(ps_i)) ##1 $stable(ps_o) [*4] ##0 done_o)
		else $error("teardown flags or length");
	a_exit_times: assert property (s_go(cltb_pkg::subroutine_exit) |-> ##4 done_o)
		else $error("near exit length");
	a_far_exit_time: assert property (s_go(cltb_pkg::far_subroutine_exit) |-> ##6 done_o)
		else $error("far exit length");
	a_dec_writeback: assert property (s_go(cltb_pkg::dec_word_reg)
		|=> wb_we_o && (wb_data_o == $past(operand_i) - 16'h0001)) else $error("loop write-back");

endmodule : cltb_unit

/* File: tb/tb_top.sv */
// self-checking random bench for the branch sequencer
`timescale 1ns/1ps
`include "cltb_map.svh"
module tb_top;
	logic               clock_i = 1'b0;
	logic               reset_n_i = 1'b0;
	logic               start_i = 1'b0;
	cltb_pkg::cltb_op_t op_i = cltb_pkg::cmp_byte_acc;
	logic [31:0]        acc_i = '0;
	logic [15:0]        operand_i = '0, imm_i = '0, next_pc_i = '0, ps_i = '0;
	logic [15:0]        sp_i = '0, fp_i = '0, bank_i = '0, xfer_rdata_i = '0;
	logic [7:0]         disp_i = '0, local_i = '0, vector_i = '0, pcb_i = '0;
	logic [7:0]         stack_bank_i = '0;
	logic [23:0]        far_addr_i = '0, opnd_addr_i = '0;
	logic [3:0]         addr_cycles_i = '0;
	logic               busy_o, done_o, branch_o, wb_we_o, regbank_rd_o;
	logic               xfer_req_o, xfer_we_o, xfer_byte_o, xfer_rmw_o;
	logic [15:0]        pc_o, ps_o, sp_o, fp_o, bank_o, wb_data_o, xfer_wdata_o;
	logic [7:0]         pcb_o;
	logic [31:0]        acc_o;
	logic [23:0]        xfer_addr_o;
	logic [15:0]        last_wb = '0;
	logic               rdh = 1'b0;
	integer             seed = 32'h5b69, error_cnt = 0, cmp_count = 0, nxf = 0, nrb = 0;

	cltb_unit dut (.clock_i, .reset_n_i, .start_i, .op_i, .acc_i, .operand_i, .imm_i,
		.disp_i, .local_i, .vector_i, .far_addr_i, .opnd_addr_i, .addr_cycles_i,
		.next_pc_i, .pcb_i, .ps_i, .sp_i, .fp_i, .bank_i, .stack_bank_i, .xfer_rdata_i,
		.busy_o, .done_o, .branch_o, .pc_o, .pcb_o, .ps_o, .sp_o, .fp_o, .acc_o, .bank_o,
		.wb_we_o, .wb_data_o, .regbank_rd_o, .xfer_req_o, .xfer_we_o, .xfer_byte_o,
		.xfer_rmw_o, .xfer_addr_o, .xfer_wdata_o);

	always #12.5 clock_i = ~clock_i;

	// memory content is a pure function of the address
	function automatic logic [15:0] mw(input logic [23:0] a);
		return a[15:0] ^ 16'h3c5a;
	endfunction : mw

	// ------------------------------------------------------------------------
	// memory side: read data held one cycle, scrambled when nobody reads
	// ------------------------------------------------------------------------
	always @(negedge clock_i) begin
		if (xfer_req_o && !xfer_we_o)
			xfer_rdata_i <= mw(xfer_addr_o);
		else if (!rdh)
			xfer_rdata_i <= ~xfer_rdata_i;
		rdh <= xfer_req_o && !xfer_we_o;
		if (xfer_req_o)
			nxf <= nxf + 1;
		if (regbank_rd_o)
			nrb <= nrb + 1;
		if (wb_we_o)
			last_wb <= wb_data_o;
		if (xfer_req_o && xfer_we_o && xfer_rmw_o)
			last_wb <= xfer_wdata_o;
	end

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (e !== g) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask : chk

	task automatic stop_test;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test

	task automatic rnd;
		acc_i = $random(seed);
		{operand_i, imm_i} = $random(seed);
		{next_pc_i, ps_i} = $random(seed);
		{sp_i, fp_i} = $random(seed);
		{bank_i, disp_i, local_i} = $random(seed);
		{far_addr_i, vector_i} = $random(seed);
		{opnd_addr_i, pcb_i} = $random(seed); // one fixed operand address, no post-increment
		{stack_bank_i, addr_cycles_i} = 12'($random(seed));
	endtask : rnd

	// ------------------------------------------------------------------------
	// one instruction: predict, run, compare
	// ------------------------------------------------------------------------
	task automatic run(input logic poke);
		integer n, o, e;
		logic tk, w;
		logic [15:0] v, b, d, m, h;
		logic [3:0] f;
		logic [23:0] sa;
		o = op_i;
		sa = {stack_bank_i, sp_i};
		w = o inside {1, 4, 5, 8, 9};
		v = o < 2 ? acc_i[15:0] : (o inside {2, 4, 6, 8}) ? operand_i : mw(opnd_addr_i);
		b = o < 6 ? imm_i : 16'h0001;
		m = w ? 16'hffff : 16'h00ff;
		h = w ? 16'h8000 : 16'h0080;
		v = v & m;
		b = b & m;
		d = (v - b) & m;
		tk = o < 10 && d != 16'h0000;
		f = {(d & h) != 0, d == 0, ((v ^ b) & (v ^ d) & h) != 0, o < 6 ? v < b : ps_i[0]};
		case (o)
			0, 1: e = 4;
			2: e = 12;
			4: e = 7;
			3, 5: e = 6 + addr_cycles_i;
			6, 8: e = 6;
			7, 9: e = 7 + addr_cycles_i;
			10, 13: e = 20;
			11: e = 16;
			12: e = 17;
			14: e = 15;
			15, 18: e = 6;
			16: e = 5;
			default: e = 4;
		endcase
		e = e + tk;
		@(negedge clock_i);
		nxf = 0;
		nrb = 0;
		start_i = 1'b1;
		@(negedge clock_i);
		n = 1;
		while (done_o !== 1'b1 && n < 60) begin
			start_i = poke && n == 2;
			@(negedge clock_i);
			n = n + 1;
		end
		start_i = 1'b0;
		chk("cycles", e, n);
		if (o < 10) begin
			chk("branch", tk, branch_o);
			chk("ps", {ps_i[15:4], f}, ps_o);
		end
		if (tk)
			chk("pc", 16'(next_pc_i + {{8{disp_i[7]}}, disp_i}), pc_o);
		if (o > 5 && o < 10)
			chk("wb", d, last_wb & m);
		if (o inside {2, 4})
			chk("regrd", 1, nrb);
		if (o inside {7, 9})
			chk("xfers", 2, nxf);
		if (o inside {10, 13})
			chk("xfers", 8, nxf);
		if (o > 9 && o < 14) begin
			chk("ie_ss", 2'b01, ps_o[6:5]);
			chk("trap_sp", 16'(sp_i - 16'h000c), sp_o);
		end
		if (o inside {11, 12}) begin
			chk("xfers", 6, nxf);
			chk("trap_pc", far_addr_i[15:0], pc_o);
			chk("trap_pcb", o == 12 ? far_addr_i[23:16] : pcb_i, pcb_o);
		end
		if (o == 14) begin
			chk("xfers", 6, nxf);
			chk("ps", mw(sa), ps_o);
			chk("pc", mw(sa + 24'h2), pc_o);
			chk("pcb", mw(sa + 24'h4) & 16'h00ff, pcb_o);
			chk("bank", mw(sa + 24'h6), bank_o);
			chk("acc", {mw(sa + 24'ha), mw(sa + 24'h8)}, acc_o);
			chk("sp", 16'(sp_i + 16'h000c), sp_o);
		end
		if (o > 14)
			chk("ps", ps_i, ps_o);
		if (o == 15) begin
			chk("fp", 16'(sp_i - 16'h0002), fp_o);
			chk("sp", 16'(sp_i - 16'h0002 - {8'h00, local_i}), sp_o);
		end
		if (o == 16) begin
			chk("fp", mw({stack_bank_i, fp_i}), fp_o);
			chk("sp", 16'(fp_i + 16'h0002), sp_o);
		end
		if (o > 16) begin
			chk("ret_pc", mw(sa), pc_o);
			chk("ret_sp", 16'(sp_i + (o == 18 ? 16'h0004 : 16'h0002)), sp_o);
		end
		if (o == 18)
			chk("ret_pcb", mw(sa + 24'h2) & 16'h00ff, pcb_o);
	endtask : run

	initial begin
		repeat (3) @(posedge clock_i);
		@(negedge clock_i);
		reset_n_i = 1'b1;
		chk("busy", 0, busy_o);
		for (integer i = 0; i < 150; i++) begin
			rnd();
			op_i = cltb_pkg::cltb_op_t'(5'(i < 19 ? i : {$random(seed)} % 19));
			// equal compares, loop reaching zero, sign-overflow operand
			if (i % 4 == 2) begin
				operand_i = i % 8 == 2 ? acc_i[15:0] : 16'h0001;
				imm_i = operand_i;
			end
			if (i % 8 == 3)
				operand_i = 16'h8080;
			run(i % 5 == 3);
		end
		stop_test();
	end

	initial begin
		#200000;
		error_cnt++;
		stop_test();
	end
endmodule : tb_top
